/* File: hw/ppcl_pkg.sv */
// shared constants for the peripheral config lock and status bank
package ppcl_pkg;
  // byte addresses of the three registers
  localparam logic [31:0] PPCL_PERIPH_EN_ADDR = 32'h01b3f000;
  localparam logic [31:0] PPCL_STRAP_ADDR     = 32'h01b3f004;
  localparam logic [31:0] PPCL_GUARD_ADDR     = 32'h01b3f018;

  // unlock key written to the guard register
  localparam logic [31:0] PPCL_UNLOCK_KEY     = 32'h10c0010c;

  // peripheral enable register: writable bits and reset value
  localparam logic [31:0] PPCL_PERIPH_EN_MASK = 32'h0000006f;
  localparam logic [31:0] PPCL_PERIPH_EN_RST  = 32'h00000006;

  // guard register read view
  localparam int          PPCL_GUARD_BIT      = 0;
  localparam logic        PPCL_GUARD_RST      = 1'b1;

  // status field positions
  localparam int PPCL_ETH_BIT     = 11;
  localparam int PPCL_HPW_BIT     = 10;
  localparam int PPCL_MULT_LSB    = 5;
  localparam int PPCL_ORDER_BIT   = 4;
  localparam int PPCL_BOOT_LSB    = 2;
  localparam int PPCL_EXTCLK_LSB  = 0;

  // status defaults until the straps are captured
  localparam logic       PPCL_ETH_RST    = 1'b0;
  localparam logic       PPCL_HPW_RST    = 1'b0;
  localparam logic [1:0] PPCL_MULT_RST   = 2'h0;
  localparam logic       PPCL_ORDER_RST  = 1'b1;
  localparam logic [1:0] PPCL_BOOT_RST   = 2'h0;
  localparam logic [1:0] PPCL_EXTCLK_RST = 2'h0;

  // cycles a newly enabled peripheral must be left alone
  localparam int PPCL_SETTLE_CYCLES = 128;

  // axi responses
  localparam logic [1:0] PPCL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPCL_RESP_SLVERR = 2'h2;

  // register selected by an address
  typedef enum logic [1:0] {
    PPCL_SEL_NONE,
    PPCL_SEL_PERIPH,
    PPCL_SEL_STRAP,
    PPCL_SEL_GUARD
  } ppcl_sel_e;

  // address decode, shared by the read and the write path
  function automatic ppcl_sel_e ppcl_decode(input logic [31:0] addr);
    ppcl_sel_e sel;
    sel = PPCL_SEL_NONE;
    if (addr == PPCL_PERIPH_EN_ADDR) begin
      sel = PPCL_SEL_PERIPH;
    end else if (addr == PPCL_STRAP_ADDR) begin
      sel = PPCL_SEL_STRAP;
    end else if (addr == PPCL_GUARD_ADDR) begin
      sel = PPCL_SEL_GUARD;
    end
    return sel;
  endfunction
endpackage

/* File: hw/ppcl_strap_capture.sv */
// strap synchroniser and one-shot capture at reset release
`timescale 1ns/1ps
`default_nettype none
module ppcl_strap_capture (
  input  wire  logic       aclk,
  input  wire  logic       aresetn,
  input  wire  logic       ce,
  input  wire  logic [8:0] strap_raw,
  output logic       [8:0] strap_held,
  output logic             captured
);
  import ppcl_pkg::*;

  localparam logic [8:0] STRAP_RST = {PPCL_ETH_RST, PPCL_HPW_RST,
    PPCL_MULT_RST, PPCL_ORDER_RST, PPCL_BOOT_RST, PPCL_EXTCLK_RST};

  logic [8:0] sync1_r;
  logic [8:0] sync2_r;
  logic [8:0] held_r;
  logic       captured_r;

  // two-stage synchroniser; runs through reset so the pins are settled
  always_ff @(posedge aclk) begin
    if (ce) begin
      sync1_r <= strap_raw;
      sync2_r <= sync1_r;
    end
  end

  // capture once, on the first enabled edge after release; the pins are
  // ignored from then on so later pull changes cannot move the owners
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held_r     <= STRAP_RST;
      captured_r <= 1'b0;
    end else if (ce && !captured_r) begin
      held_r     <= sync2_r;
      captured_r <= 1'b1;
    end
  end

  assign strap_held = held_r;
  assign captured   = captured_r;
endmodule
`default_nettype wire

/* File: hw/ppcl_top.sv */
// peripheral enable guard, lock and strap status bank on axi4-lite
`timescale 1ns/1ps
`default_nettype none
module ppcl_top #(
  parameter int SETTLE_CYCLES = ppcl_pkg::PPCL_SETTLE_CYCLES
) (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic        ce,
  // axi4-lite write address
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_awaddr,
  input  wire  logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  output logic [1:0]        s_axi_bresp,
  // axi4-lite read address
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  input  wire  logic [31:0] s_axi_araddr,
  input  wire  logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  // strap pins, asynchronous to aclk
  input  wire  logic        strap_eth_en,
  input  wire  logic        strap_host_port_width,
  input  wire  logic [1:0]  strap_cpu_multiplier,
  input  wire  logic        strap_byte_order,
  input  wire  logic [1:0]  strap_boot_source,
  input  wire  logic [1:0]  strap_ext_clock_select,
  // block outputs
  output logic [31:0]       periph_enable,
  output logic              guard_locked,
  output logic              periph_settling,
  output logic              ethernet_enabled_status,
  output logic              host_port_width,
  output logic [1:0]        cpu_multiplier_select,
  output logic              byte_order_status,
  output logic [1:0]        boot_source_status,
  output logic [1:0]        ext_mem_clock_select
);
  import ppcl_pkg::*;

  typedef enum logic {
    PPCL_RD_IDLE,
    PPCL_RD_RESP
  } ppcl_rd_e;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO    = '0;
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

  // packing of the captured straps, lowest field first
  localparam int HELD_EXT   = 0;
  localparam int HELD_BOOT  = 2;
  localparam int HELD_ORDER = 4;
  localparam int HELD_MULT  = 5;
  localparam int HELD_HPW   = 7;
  localparam int HELD_ETH   = 8;

  // write channel holding registers
  logic        aw_held_r;
  logic [31:0] aw_addr_r;
  logic        w_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        awready_r;
  logic        wready_r;

  // read channel
  ppcl_rd_e    rd_state_r;
  logic        arready_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic        rvalid_r;

  // block state
  logic [31:0] periph_en_r;
  logic [31:0] periph_en_nxt;
  logic        locked_r;
  logic [CNT_W-1:0] settle_cnt_r;
  logic        settling_r;

  // strap capture
  logic [8:0]  strap_held;
  logic        strap_done;
  logic [31:0] strap_word;

  // write execution decode and the read address decode
  logic        wr_fire;
  ppcl_sel_e   wr_sel;
  ppcl_sel_e   rd_sel;
  logic        key_match;
  logic        enables_rising;

  ppcl_strap_capture u_strap (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .strap_raw  ({strap_eth_en, strap_host_port_width,
                  strap_cpu_multiplier, strap_byte_order,
                  strap_boot_source, strap_ext_clock_select}),
    .strap_held (strap_held),
    .captured   (strap_done)
  );

  // status word: reserved ranges 31:12 and 9:7 stay zero
  always_comb begin
    strap_word = '0;
    strap_word[PPCL_ETH_BIT] = strap_held[HELD_ETH];
    strap_word[PPCL_HPW_BIT] = strap_held[HELD_HPW];
    strap_word[PPCL_MULT_LSB +: 2] = strap_held[HELD_MULT +: 2];
    strap_word[PPCL_ORDER_BIT] = strap_held[HELD_ORDER];
    strap_word[PPCL_BOOT_LSB +: 2] = strap_held[HELD_BOOT +: 2];
    // reserved code 11 is passed on as captured; the pins decide
    strap_word[PPCL_EXTCLK_LSB +: 2] = strap_held[HELD_EXT +: 2];
  end

  // a write executes once both address and data are held and the
  // previous response has been taken
  // a stalled response therefore also stalls the next write; no queue needed
  assign wr_fire   = ce && aw_held_r && w_held_r && !bvalid_r;
  assign wr_sel    = ppcl_decode(aw_addr_r);
  assign rd_sel    = ppcl_decode(s_axi_araddr);
  // the key counts only when all four lanes carry it
  // a partial key write would otherwise unlock on stale lanes
  assign key_match = (w_strb_r == 4'hf) &&
                     (w_data_r == PPCL_UNLOCK_KEY);

  // merge strobed lanes into the writable enable bits
  always_comb begin
    periph_en_nxt = periph_en_r;
    for (int i = 0; i < 4; i++) begin
      if (w_strb_r[i]) begin
        periph_en_nxt[i*8 +: 8] = w_data_r[i*8 +: 8];
      end
    end
    periph_en_nxt = periph_en_nxt & PPCL_PERIPH_EN_MASK;
  end

  assign enables_rising = |(periph_en_nxt & ~periph_en_r);

  // write address channel: one address held at a time
  // ready is its own flop, the inverse of the held flag, so no gate drives it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
      aw_addr_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
        awready_r <= 1'b1;
      end
    end
  end

  // write data channel, independent of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (ce) begin
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
        wready_r <= 1'b1;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= PPCL_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_sel == PPCL_SEL_NONE ?
                    PPCL_RESP_SLVERR : PPCL_RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // peripheral enables change only from an unlocked state
  // the lock is sampled before this write's own relock lands, so the
  // write that relocks the guard is still honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_en_r <= PPCL_PERIPH_EN_RST;
    end else if (ce && wr_fire && wr_sel == PPCL_SEL_PERIPH) begin
      if (!locked_r) begin
        periph_en_r <= periph_en_nxt;
      end // a locked write is dropped silently
    end
  end

  // lock state: key clears it, any enable write sets it again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_r <= PPCL_GUARD_RST;
    end else if (ce && wr_fire) begin
      if (wr_sel == PPCL_SEL_PERIPH) begin
        locked_r <= 1'b1;
      end else if (wr_sel == PPCL_SEL_GUARD && key_match) begin
        locked_r <= 1'b0;
      end
    end
  end

  // settle window after a peripheral is newly enabled; software still
  // owns the wait, this only lets the fabric observe it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_cnt_r <= CNT_ZERO;
      settling_r   <= 1'b0;
    end else if (ce) begin
      if (wr_fire && wr_sel == PPCL_SEL_PERIPH && !locked_r &&
          enables_rising) begin
        settle_cnt_r <= SETTLE_LOAD;
        settling_r   <= 1'b1;
      end else if (settle_cnt_r != CNT_ZERO) begin
        settle_cnt_r <= settle_cnt_r - CNT_ONE;
        settling_r   <= settle_cnt_r != CNT_ONE;
      end
    end
  end

  // read channel: an address is refused while any write is in flight,
  // so a read issued after a write always sees its result
  // rvalid has its own flop for the same reason as the ready outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= PPCL_RD_IDLE;
      rvalid_r   <= 1'b0;
      arready_r  <= 1'b0;
      rdata_r    <= '0;
      rresp_r    <= PPCL_RESP_OKAY;
    end else if (ce) begin
      unique case (rd_state_r)
        PPCL_RD_IDLE: begin
          arready_r <= 1'b0;
          if (s_axi_arvalid && !arready_r && !aw_held_r && !w_held_r &&
              !bvalid_r) begin
            arready_r  <= 1'b1;
            rvalid_r   <= 1'b1;
            rd_state_r <= PPCL_RD_RESP;
            rresp_r    <= PPCL_RESP_OKAY;
            unique case (rd_sel)
              PPCL_SEL_PERIPH: rdata_r <= periph_en_r;
              PPCL_SEL_STRAP:  rdata_r <= strap_word;
              PPCL_SEL_GUARD: begin
                rdata_r <= '0;
                rdata_r[PPCL_GUARD_BIT] <= locked_r;
              end
              PPCL_SEL_NONE: begin
                rdata_r <= '0;
                rresp_r <= PPCL_RESP_SLVERR;
              end
            endcase
          end
        end
        PPCL_RD_RESP: begin
          arready_r <= 1'b0;
          if (s_axi_rready) begin
            rvalid_r   <= 1'b0;
            rd_state_r <= PPCL_RD_IDLE;
          end
        end
      endcase
    end
  end

  // axi outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // block outputs
  assign periph_enable           = periph_en_r;
  assign guard_locked            = locked_r;
  assign periph_settling         = settling_r;
  // status follows the capture flops, never the live strap pins
  assign ethernet_enabled_status = strap_held[HELD_ETH];
  assign host_port_width         = strap_held[HELD_HPW];
  assign cpu_multiplier_select   = strap_held[HELD_MULT +: 2];
  assign byte_order_status       = strap_held[HELD_ORDER];
  assign boot_source_status      = strap_held[HELD_BOOT +: 2];
  assign ext_mem_clock_select    = strap_held[HELD_EXT +: 2];
endmodule
`default_nettype wire

/* File: tb/ppcl_chk.sv */
// port-level assertions for the peripheral config lock and status bank
`timescale 1ns/1ps
`default_nettype none
module ppcl_chk #(
  parameter int SETTLE_CYCLES = 128
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] periph_enable,
  input  wire logic        guard_locked,
  input  wire logic        periph_settling,
  input  wire logic        ethernet_enabled_status,
  input  wire logic        host_port_width,
  input  wire logic [1:0]  cpu_multiplier_select,
  input  wire logic        byte_order_status,
  input  wire logic [1:0]  boot_source_status,
  input  wire logic [1:0]  ext_mem_clock_select
);
  import ppcl_pkg::*;
  logic [15:0] settle_cnt_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // length of the current settling run, so a stuck flag is caught early;
  // only enabled cycles count, as a low ce freezes the design's own count
  always_ff @(posedge aclk) begin
    if (!aresetn || !periph_settling) begin
      settle_cnt_r <= 16'h0;
    end else if (ce) begin
      settle_cnt_r <= settle_cnt_r + 16'h1;
    end
  end

  chk_reset_lock: assert property (
    $rose(aresetn) |-> guard_locked && periph_enable == PPCL_PERIPH_EN_RST)
    else $error("lock or enable not at reset value");
  chk_locked_hold: assert property (
    guard_locked |=> $stable(periph_enable))
    else $error("enable changed while locked");
  chk_write_relock: assert property (
    $changed(periph_enable) |-> guard_locked)
    else $error("enable write left the guard open");
  chk_unlock_write: assert property (
    $fell(guard_locked) |-> $rose(s_axi_bvalid))
    else $error("lock cleared without a completed write");
  chk_status_hold: assert property (
    $past(aresetn) && $past(aresetn, 2) |-> $stable({ethernet_enabled_status,
    host_port_width, cpu_multiplier_select, byte_order_status,
    boot_source_status, ext_mem_clock_select}))
    else $error("status changed after capture");
  chk_read_order: assert property (
    $rose(s_axi_arready) |-> $past(s_axi_awready) && $past(s_axi_wready)
    && !$past(s_axi_bvalid))
    else $error("read accepted with a write in flight");
  chk_b_after_both: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready longer than one cycle");
  chk_enable_mask: assert property (
    (periph_enable & ~PPCL_PERIPH_EN_MASK) == 32'h0)
    else $error("reserved enable bit set");
  chk_settle_bound: assert property (
    settle_cnt_r <= SETTLE_CYCLES)
    else $error("settling flag held too long");
endmodule

bind ppcl_top ppcl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .periph_enable(periph_enable),
  .guard_locked(guard_locked), .periph_settling(periph_settling),
  .ethernet_enabled_status(ethernet_enabled_status),
  .host_port_width(host_port_width),
  .cpu_multiplier_select(cpu_multiplier_select),
  .byte_order_status(byte_order_status),
  .boot_source_status(boot_source_status),
  .ext_mem_clock_select(ext_mem_clock_select));
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the peripheral config lock and status bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppcl_pkg::*;
  localparam int SETTLE = 4;
  localparam logic [31:0] A_EN = PPCL_PERIPH_EN_ADDR;
  localparam logic [31:0] A_ST = PPCL_STRAP_ADDR;
  localparam logic [31:0] A_GD = PPCL_GUARD_ADDR;
  localparam logic [31:0] A_NO = 32'h01b3f008;
  localparam logic [31:0] KEY  = PPCL_UNLOCK_KEY;
  localparam logic [1:0]  OK   = PPCL_RESP_OKAY;
  localparam logic [1:0]  SE   = PPCL_RESP_SLVERR;
  typedef struct {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
    logic [1:0]  resp;
  } ppcl_row_s;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        guard_locked, periph_settling, eth_o, hpw_o, order_o;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] periph_enable;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  prot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mult_o, boot_o, ext_o;
  logic [8:0]  strap;
  int          err_total, n_checks;
  // only the bank itself is reached, never a peripheral
  // reads carry expected data; strap set at first reset gives 0xc4d
  ppcl_row_s   rows [20] = '{
    '{1'b0, A_GD, 32'h1, 4'hf, OK},
    '{1'b1, A_EN, 32'h6f, 4'hf, OK},
    '{1'b0, A_EN, 32'h6, 4'hf, OK},
    '{1'b1, A_GD, KEY, 4'hf, OK},
    '{1'b0, A_GD, 32'h0, 4'hf, OK},
    '{1'b0, A_EN, 32'h6, 4'hf, OK},
    '{1'b1, A_EN, 32'h6f, 4'hf, OK},
    '{1'b0, A_EN, 32'h6f, 4'hf, OK},
    '{1'b0, A_GD, 32'h1, 4'hf, OK},
    '{1'b1, A_GD, 32'hffffffff, 4'hf, OK},
    '{1'b0, A_GD, 32'h1, 4'hf, OK},
    '{1'b1, A_ST, 32'h0, 4'hf, OK},
    '{1'b0, A_ST, 32'hc4d, 4'hf, OK},
    '{1'b0, A_NO, 32'h0, 4'hf, SE},
    '{1'b1, A_NO, 32'h0, 4'hf, SE},
    '{1'b1, A_GD, KEY, 4'h7, OK},
    '{1'b0, A_GD, 32'h1, 4'hf, OK},
    '{1'b1, A_GD, KEY, 4'hf, OK},
    '{1'b1, A_EN, 32'hffffff01, 4'h1, OK},
    '{1'b0, A_EN, 32'h1, 4'hf, OK}};
  logic [8:0]  straps [3] = '{9'b0_0_00_1_00_00, 9'b1_1_01_0_01_01,
                              9'b0_1_10_1_11_10};

  ppcl_top #(.SETTLE_CYCLES(SETTLE)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(prot),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(prot), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .strap_eth_en(strap[8]),
    .strap_host_port_width(strap[7]), .strap_cpu_multiplier(strap[6:5]),
    .strap_byte_order(strap[4]), .strap_boot_source(strap[3:2]),
    .strap_ext_clock_select(strap[1:0]), .periph_enable(periph_enable),
    .guard_locked(guard_locked), .periph_settling(periph_settling),
    .ethernet_enabled_status(eth_o), .host_port_width(hpw_o),
    .cpu_multiplier_select(mult_o), .byte_order_status(order_o),
    .boot_source_status(boot_o), .ext_mem_clock_select(ext_o));

  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] rsp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // rready stays up until the data beat is seen
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] rsp);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!(ar_ok && r_ok)) begin
      @(posedge aclk);
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (!r_ok && s_axi_rvalid === 1'b1) begin
        r_ok = 1'b1;
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  // straps only matter while reset is low, so they move afterwards
  task automatic reset_with(input logic [8:0] s);
    logic [31:0] d;
    logic [1:0]  rsp;
    @(posedge aclk);
    aresetn <= 1'b0;
    strap <= s;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("lock after reset", {31'h0, guard_locked}, 32'h1);
    check("enable at reset", periph_enable, PPCL_PERIPH_EN_RST);
    strap <= ~s;
    axi_read(A_ST, d, rsp);
    check("status", d, {20'h0, s[8:7], 3'h0, s[6:0]});
    check("status pins", {23'h0, eth_o, hpw_o, mult_o, order_o, boot_o,
          ext_o}, {23'h0, s});
  endtask

  // watchdog, far beyond the roughly 150 cycles the tests take
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    summarize();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  rsp;
    logic [1:0]  rrsp;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'h0;
    prot = 3'h0;
    ce = 1'b1;
    strap = 9'h0;
    err_total = 0;
    n_checks = 0;
    reset_with(9'b1_1_10_0_11_01);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi_write(rows[i].addr, rows[i].data, rows[i].strb, rsp);
      end else begin
        axi_read(rows[i].addr, d, rsp);
        check($sformatf("row %0d data", i), d, rows[i].data);
      end
      check($sformatf("row %0d resp", i), {30'h0, rsp}, {30'h0, rows[i].resp});
    end
    // newly set enables raise the settling flag for a bounded time
    // all enables go in one write after one unlock
    axi_write(A_EN, 32'h0, 4'hf, rsp);
    check("locked enable", periph_enable, 32'h1);
    axi_write(A_GD, KEY, 4'hf, rsp);
    axi_write(A_EN, 32'h6f, 4'hf, rsp);
    check("settling on", {31'h0, periph_settling}, 32'h1);
    check("enable pins", periph_enable, 32'h6f);
    check("relocked", {31'h0, guard_locked}, 32'h1);
    // a low clock enable freezes the settle count mid-run
    ce <= 1'b0;
    repeat (SETTLE + 2) @(posedge aclk);
    check("settle frozen", {31'h0, periph_settling}, 32'h1);
    ce <= 1'b1;
    repeat (SETTLE + 2) @(posedge aclk);
    check("settling off", {31'h0, periph_settling}, 32'h0);
    // a read issued one cycle behind an enable write must see its result
    axi_write(A_GD, KEY, 4'hf, rsp);
    fork
      axi_write(A_EN, 32'h2f, 4'hf, rsp);
      begin
        @(posedge aclk);
        axi_read(A_EN, d, rrsp);
      end
    join
    check("read after write", d, 32'h2f);
    check("read after write resp", {30'h0, rrsp}, {30'h0, OK});
    foreach (straps[k]) begin
      reset_with(straps[k]);
    end
    summarize();
  end
endmodule
`default_nettype wire
